/* File: hw/rxf_port.sv */
// Receive fabric port: link-side buffers, fabric read-out, status RAM and delay controls.
//
// How it works
// - Status port index addresses the status RAM write.
// - Status code stored for the indexed port.
// - External select sends fabric status, not automatic.
// - Status RAM written only with write enable.
// - Writes timed by fabric status write clock.
// - Delay enable low bypasses, high inserts delay.
// - Three-bit tap sets delay, values zero to six.
// - Status clock is receive data clock over four.
// - Sixteen byte valids, top bit for top byte.
// - Eight-bit port identifier with every read word.
// - Packet start high only on first word.
// - Packet end high only on last word.
// - Word error high for an errored word.
// - Empty flag true or quarter-minus-one by configuration.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "rxf_defines.svh"
module rxf_port
    import rxf_pkg::*;
#(
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_data_clk,
    input wire logic link_valid,
    input wire logic [`RXF_SELW-1:0] link_buffer,
    input wire logic [`RXF_ENTRYW-1:0] link_entry,
    output logic rx_status_clk,
    input wire logic rx_read_clk,
    input wire logic rx_read_strobe,
    input wire logic [`RXF_SELW-1:0] rx_buffer_select,
    output logic [`RXF_DATAW-1:0] rx_read_word,
    output logic [`RXF_BEW-1:0] rx_byte_valid,
    output logic [`RXF_PORTW-1:0] rx_word_port,
    output logic rx_packet_start,
    output logic rx_packet_end,
    output logic rx_word_error,
    output logic rx_read_valid,
    output logic [`RXF_NBUF-1:0] rx_buffer_empty_flag,
    input wire logic status_ram_write_clk,
    input wire logic status_ram_write_en,
    input wire logic [`RXF_PORTW-1:0] status_port_index,
    input wire logic [1:0] port_status_code,
    input wire logic external_status_select,
    input wire logic [`RXF_PORTW-1:0] status_poll_port,
    output logic [1:0] status_to_link,
    input wire logic static_capture_delay_en,
    input wire logic [2:0] capture_delay_tap,
    output logic delay_line_enable,
    output logic [2:0] delay_tap
);
    localparam int DEPTH = 1 << AW;
    localparam logic [AW:0] QTR_M1 = (AW+1)'(DEPTH/4 - 1);

    // Gray code to binary, used on the write pointer crossing.
    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : g2b

    // Buffer storage for all buffers; each instance owns its own copy.
    logic [`RXF_ENTRYW-1:0] mem [`RXF_NBUF*DEPTH];
    logic [1:0] stat_ram [`RXF_NPORT]; // Per-port status entries.

    // ---------------- Link domain ----------------
    logic lrst_meta_q, lrst_q; // Reset carried into the link domain.
    logic [1:0] div_q, div_d; // Status clock divider.
    logic sclk_q, sclk_d; // Divided status clock.
    logic [AW:0] wbin_q [`RXF_NBUF], wgray_q [`RXF_NBUF]; // Write pointer, binary and gray.
    logic [AW:0] rg_meta_q [`RXF_NBUF], rg_sync_q [`RXF_NBUF]; // Read pointer crossing.
    logic [`RXF_NBUF-1:0] full; // Per buffer, in the link domain.

    // The system reset is re-timed so that link logic leaves reset on its own edge.
    always_ff @(posedge rx_data_clk) begin
        lrst_meta_q <= sys_rst;
        lrst_q <= lrst_meta_q;
    end

    // Divide by four: the top counter bit has a period of four link clocks.
    always_comb begin
        div_d = div_q + 2'd1;
        sclk_d = div_d[1];
    end

    always_ff @(posedge rx_data_clk) begin
        if (lrst_q) begin
            div_q <= 2'd0;
            sclk_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sclk_q <= sclk_d;
        end
    end

    // Words arriving while their buffer is full are dropped; the link has no stall.
    always_ff @(posedge rx_data_clk) begin
        if (link_valid && !full[link_buffer]) begin
            mem[{link_buffer, wbin_q[link_buffer][AW-1:0]}] <= link_entry;
        end
    end

    // ---------------- System domain ----------------
    logic [`RXF_PINW-1:0] pin_meta_q, pin_sync_q; // Two-stage pin synchroniser.
    logic rclk_old_q, wclk_old_q; // Previous synced fabric clock levels.
    logic ctrl_type_q, ctrl_type_d; // Empty flag type select.
    logic [AW:0] rbin_q [`RXF_NBUF], rgray_q [`RXF_NBUF]; // Read pointer, binary and gray.
    logic [AW:0] wg_meta_q [`RXF_NBUF], wg_sync_q [`RXF_NBUF]; // Write pointer crossing.
    logic [`RXF_NBUF-1:0] empty_true, empty_d, empty_q;
    logic [`RXF_ENTRYW-1:0] ent_q, ent_d; // Word on the read-out ports.
    rxf_stat_t stat_q, stat_d;
    logic dly_en_q, dly_en_d, pready_q, pready_d, pslverr_q, pslverr_d;
    logic [2:0] tap_q, tap_d, s_sel, s_tap;
    logic [31:0] prdata_q, prdata_d;
    logic valid_q, valid_d, s_rclk, s_rstb, s_wclk, s_we, s_dlyen, s_ext;
    logic [7:0] s_idx, s_poll;
    logic [1:0] s_code, ram_sel;
    logic rd_evt, wr_evt, pop;
    logic [`RXF_ENTRYW-1:0] rd_entry;
    rxf_src_t src;

    // All fabric pins cross together; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        pin_meta_q <= {rx_read_clk, rx_read_strobe, rx_buffer_select, status_ram_write_clk,
                       status_ram_write_en, status_port_index, port_status_code,
                       external_status_select, static_capture_delay_en, capture_delay_tap,
                       status_poll_port};
        pin_sync_q <= pin_meta_q;
    end

    assign {s_rclk, s_rstb, s_sel, s_wclk, s_we, s_idx, s_code, s_ext, s_dlyen, s_tap,
            s_poll} = pin_sync_q;

    // Fields launched on a fabric rising edge are taken at its falling edge, mid-period,
    // so skew between the synced clock and its data cannot tear a value.
    assign rd_evt = rclk_old_q && !s_rclk;
    assign wr_evt = wclk_old_q && !s_wclk && s_we;
    assign pop = rd_evt && s_rstb && !empty_true[s_sel];
    assign rd_entry = mem[{s_sel, rbin_q[s_sel][AW-1:0]}];
    assign ram_sel = stat_ram[s_poll];
    assign src = s_ext ? RXF_SRC_EXT : RXF_SRC_AUTO;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rclk_old_q <= 1'b0;
            wclk_old_q <= 1'b0;
        end else begin
            rclk_old_q <= s_rclk;
            wclk_old_q <= s_wclk;
        end
    end

    // The status RAM holds no reset; its contents are whatever the fabric wrote.
    always_ff @(posedge clk) begin
        if (wr_evt) begin
            stat_ram[s_idx] <= s_code;
        end
    end

    // Per-buffer pointers, crossings and flags.
    for (genvar b = 0; b < `RXF_NBUF; b++) begin : g_buf
        logic [AW:0] wbin_d, rbin_d, cnt;
        // Write pointer advances on an accepted link word.
        always_comb begin
            wbin_d = wbin_q[b];
            if (link_valid && link_buffer == (`RXF_SELW)'(b) && !full[b]) begin
                wbin_d = wbin_q[b] + 1'b1;
            end
        end
        assign full[b] = wgray_q[b] == {~rg_sync_q[b][AW:AW-1], rg_sync_q[b][AW-2:0]};
        always_ff @(posedge rx_data_clk) begin
            if (lrst_q) begin
                wbin_q[b] <= '0;
                wgray_q[b] <= '0;
                rg_meta_q[b] <= '0;
                rg_sync_q[b] <= '0;
            end else begin
                wbin_q[b] <= wbin_d;
                wgray_q[b] <= wbin_d ^ (wbin_d >> 1);
                rg_meta_q[b] <= rgray_q[b];
                rg_sync_q[b] <= rg_meta_q[b];
            end
        end
        // Read pointer advances on a pop of this buffer.
        always_comb begin
            rbin_d = rbin_q[b];
            if (pop && s_sel == (`RXF_SELW)'(b)) begin
                rbin_d = rbin_q[b] + 1'b1;
            end
            cnt = g2b(wg_sync_q[b]) - rbin_q[b];
            empty_true[b] = cnt == '0;
            // Flag is late by the crossing, so it may read empty a little long.
            empty_d[b] = ctrl_type_q ? (cnt <= QTR_M1) : empty_true[b];
        end
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                rbin_q[b] <= '0;
                rgray_q[b] <= '0;
                wg_meta_q[b] <= '0;
                wg_sync_q[b] <= '0;
                empty_q[b] <= 1'b1;
            end else begin
                rbin_q[b] <= rbin_d;
                rgray_q[b] <= rbin_d ^ (rbin_d >> 1);
                wg_meta_q[b] <= wgray_q[b];
                wg_sync_q[b] <= wg_meta_q[b];
                empty_q[b] <= empty_d[b];
            end
        end
    end

    // Read-out, status choice, delay controls and the APB slave.
    always_comb begin
        ent_d = ent_q;
        valid_d = pop;
        if (pop) begin
            ent_d = rd_entry;
        end
        stat_d = (src == RXF_SRC_EXT) ? ram_sel :
                 (empty_q[s_poll[2:0]] ? `RXF_STAT_STARVING : `RXF_STAT_HUNGRY);
        // Enable low bypasses the line; taps above six are held at six.
        dly_en_d = s_dlyen;
        tap_d = !s_dlyen ? 3'h0 : (s_tap > `RXF_TAP_MAX ? `RXF_TAP_MAX : s_tap);
        ctrl_type_d = ctrl_type_q;
        // A write lands at the edge that completes the transfer, when ready is seen high.
        if (psel && penable && pready_q && pwrite && paddr == `RXF_ADDR_CTRL) begin
            ctrl_type_d = pwdata[`RXF_CTRL_EMPTY_TYPE_BIT];
        end
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        // One wait state: ready rises in the second access cycle.
        pready_d = psel && penable && !pready_q;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                `RXF_ADDR_CTRL: begin
                    prdata_d[`RXF_CTRL_EMPTY_TYPE_BIT] = ctrl_type_q;
                end
                `RXF_ADDR_EMPTY: begin
                    prdata_d[`RXF_NBUF-1:0] = empty_q;
                end
                `RXF_ADDR_DELAY: begin
                    prdata_d[3:0] = {dly_en_q, tap_q};
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ent_q <= '0;
            valid_q <= 1'b0;
            stat_q <= `RXF_STAT_STARVING;
            dly_en_q <= 1'b0;
            tap_q <= 3'h0;
            ctrl_type_q <= `RXF_CTRL_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            ent_q <= ent_d;
            valid_q <= valid_d;
            stat_q <= stat_d;
            dly_en_q <= dly_en_d;
            tap_q <= tap_d;
            ctrl_type_q <= ctrl_type_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rx_status_clk = sclk_q;
    assign rx_read_word = ent_q[`RXF_DATAW-1:0];
    assign rx_byte_valid = ent_q[`RXF_BE_LSB +: `RXF_BEW];
    assign rx_word_port = ent_q[`RXF_PID_LSB +: `RXF_PORTW];
    assign rx_packet_start = ent_q[`RXF_SOP_BIT];
    assign rx_packet_end = ent_q[`RXF_EOP_BIT];
    assign rx_word_error = ent_q[`RXF_ERR_BIT];
    assign rx_read_valid = valid_q;
    assign rx_buffer_empty_flag = empty_q;
    assign status_to_link = stat_q;
    assign delay_line_enable = dly_en_q;
    assign delay_tap = tap_q;

    // Checks.
    a_tap_range: assert property (@(posedge clk) disable iff (sys_rst)
        tap_q <= `RXF_TAP_MAX) else $error("delay tap above six");
    a_bypass_tap: assert property (@(posedge clk) disable iff (sys_rst)
        !s_dlyen |=> !dly_en_q && tap_q == 3'h0) else $error("bypass not applied");
    a_div_quarter: assert property (@(posedge rx_data_clk) disable iff (lrst_q)
        $changed(sclk_q) |=> $stable(sclk_q) ##1 $changed(sclk_q))
        else $error("status clock not a quarter");
    a_ram_store: assert property (@(posedge clk) disable iff (sys_rst)
        wr_evt |=> stat_ram[$past(s_idx)] == $past(s_code)) else $error("status not stored");
    a_ext_status: assert property (@(posedge clk) disable iff (sys_rst)
        s_ext |=> stat_q == $past(ram_sel)) else $error("external status not sent");
    a_pop_word: assert property (@(posedge clk) disable iff (sys_rst)
        pop |=> valid_q && ent_q == $past(rd_entry)) else $error("read word wrong");
    a_no_pop_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !pop |=> !valid_q && $stable(ent_q)) else $error("word changed without a read");
    a_empty_true: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl_type_q |=> empty_q == $past(empty_true)) else $error("true empty wrong");
    a_sop_field: assert property (@(posedge clk) disable iff (sys_rst)
        pop |=> rx_packet_start == $past(rd_entry[`RXF_SOP_BIT])) else $error("start wrong");
    a_eop_err: assert property (@(posedge clk) disable iff (sys_rst)
        pop |=> {rx_word_error, rx_packet_end} == $past(rd_entry[`RXF_ERR_BIT:`RXF_EOP_BIT]))
        else $error("end or error wrong");
    a_apb_ready: assert property (@(posedge clk) disable iff (sys_rst)
        psel && penable && !pready_q |=> pready_q ##1 !pready_q) else $error("ready timing");
    c_pop: cover property (@(posedge clk) disable iff (sys_rst) pop);
    c_ram_write: cover property (@(posedge clk) disable iff (sys_rst) wr_evt);
    c_ext: cover property (@(posedge clk) disable iff (sys_rst) s_ext && wr_evt);
    c_quarter: cover property (@(posedge clk) disable iff (sys_rst)
        ctrl_type_q && empty_q[0] && !empty_true[0]);
endmodule : rxf_port

/* File: hw/rxf_defines.svh */
// Shared offsets, field positions, reset values and counts of the receive fabric port.
`ifndef RXF_DEFINES_SVH
`define RXF_DEFINES_SVH
`define RXF_NBUF 8
`define RXF_SELW 3
`define RXF_PORTW 8
`define RXF_NPORT 256
`define RXF_DATAW 128
`define RXF_BEW 16
`define RXF_BE_LSB 128
`define RXF_PID_LSB 144
`define RXF_SOP_BIT 152
`define RXF_EOP_BIT 153
`define RXF_ERR_BIT 154
`define RXF_ENTRYW 155
`define RXF_ADDR_CTRL 8'h00
`define RXF_ADDR_EMPTY 8'h04
`define RXF_ADDR_DELAY 8'h08
`define RXF_CTRL_EMPTY_TYPE_BIT 0
`define RXF_CTRL_RESET 1'b0
`define RXF_TAP_MAX 3'h6
`define RXF_STAT_STARVING 2'h0
`define RXF_STAT_HUNGRY 2'h1
`define RXF_PINW 30
`endif

/* File: hw/rxf_pkg.sv */
// Types shared by the receive fabric port.
package rxf_pkg;
    typedef logic [1:0] rxf_stat_t;
    typedef enum logic {RXF_SRC_AUTO, RXF_SRC_EXT} rxf_src_t;
endpackage : rxf_pkg

/* File: sim/rxf_fabric_model.sv */
// Behavioural model of the fabric user logic that faces the receive port.
`timescale 1ns/1ps
module rxf_fabric_model (
    output logic rx_read_clk,
    output logic rx_read_strobe,
    output logic [2:0] rx_buffer_select,
    output logic status_ram_write_clk,
    output logic status_ram_write_en,
    output logic [7:0] status_port_index,
    output logic [1:0] port_status_code,
    output logic external_status_select,
    output logic [7:0] status_poll_port,
    output logic static_capture_delay_en,
    output logic [2:0] capture_delay_tap
);
    // All pins start quiet; the delay enable starts low as in dynamic alignment.
    initial begin
        {rx_read_clk, rx_read_strobe, rx_buffer_select, status_ram_write_clk} = '0;
        {status_ram_write_en, status_port_index, port_status_code} = '0;
        {external_status_select, status_poll_port} = '0;
        {static_capture_delay_en, capture_delay_tap} = '0;
    end
    // Free fabric clocks of 200 ns, so one pop never comes closer than eight cycles.
    always #100 rx_read_clk = ~rx_read_clk;
    always #100 status_ram_write_clk = ~status_ram_write_clk;
    // One read request, held for one whole fabric period.
    task pop(input logic [2:0] sel);
        @(posedge rx_read_clk);
        rx_read_strobe <= 1'b1;
        rx_buffer_select <= sel;
        @(posedge rx_read_clk);
        rx_read_strobe <= 1'b0;
        rx_buffer_select <= ~sel;
    endtask : pop
    // One status write; stale index and code are inverted so they never look valid.
    task write_status(input logic we, input logic [7:0] idx, input logic [1:0] code);
        @(posedge status_ram_write_clk);
        status_ram_write_en <= we;
        status_port_index <= idx;
        port_status_code <= code;
        @(posedge status_ram_write_clk);
        status_ram_write_en <= 1'b0;
        status_port_index <= ~idx;
        port_status_code <= ~code;
    endtask : write_status
    // Level pins; a tap above six is never applied by real fabric logic.
    task set_pins(input logic ext, input logic [7:0] poll, input logic en, input logic [2:0] tap);
        @(posedge rx_read_clk);
        external_status_select <= ext;
        status_poll_port <= poll;
        static_capture_delay_en <= en;
        capture_delay_tap <= (tap > 3'h6) ? 3'h6 : tap;
    endtask : set_pins
endmodule : rxf_fabric_model

/* File: sim/tb_top.sv */
// Self-checking testbench of the receive fabric port.
`timescale 1ns/1ps
`include "rxf_defines.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, rx_data_clk = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic err, link_valid = 1'b0, rclk, rstb, wclk, we, ext, den, dly_en, rx_valid;
    logic [2:0] link_buffer = 3'h0, rsel, tap, dly_tap;
    logic [154:0] link_entry = '0, e0, e1;
    logic rsclk, sop, eop, werr;
    logic [127:0] word;
    logic [15:0] bv;
    logic [7:0] wport, sidx, poll, eflag;
    logic [1:0] scode, stat;
    logic [7:0] s;
    int fail_count = 0, samples_checked = 0, valid_count = 0, n;
    // System clock of 25 ns and an unrelated link clock of 30 ns.
    always #12.5 clk = ~clk;
    always #15 rx_data_clk = ~rx_data_clk;
    // Counts popped words, since the valid pulse may land inside a fabric task.
    always @(posedge clk) if (rx_valid === 1'b1) valid_count <= valid_count + 1;
    rxf_port u_rxf_port (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_data_clk(rx_data_clk), .link_valid(link_valid),
        .link_buffer(link_buffer), .link_entry(link_entry), .rx_status_clk(rsclk),
        .rx_read_clk(rclk), .rx_read_strobe(rstb), .rx_buffer_select(rsel),
        .rx_read_word(word), .rx_byte_valid(bv), .rx_word_port(wport),
        .rx_packet_start(sop), .rx_packet_end(eop), .rx_word_error(werr),
        .rx_read_valid(rx_valid), .rx_buffer_empty_flag(eflag), .status_ram_write_clk(wclk),
        .status_ram_write_en(we), .status_port_index(sidx), .port_status_code(scode),
        .external_status_select(ext), .status_poll_port(poll), .status_to_link(stat),
        .static_capture_delay_en(den), .capture_delay_tap(tap),
        .delay_line_enable(dly_en), .delay_tap(dly_tap));
    rxf_fabric_model u_rxf_fabric_model (.rx_read_clk(rclk), .rx_read_strobe(rstb),
        .rx_buffer_select(rsel), .status_ram_write_clk(wclk), .status_ram_write_en(we),
        .status_port_index(sidx), .port_status_code(scode), .external_status_select(ext),
        .status_poll_port(poll), .static_capture_delay_en(den), .capture_delay_tap(tap));
    // One APB transfer; the request is held until pready is seen at an edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count is assumed; only the watchdog ends a wait that never completes.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    // Writes one word into a buffer from the link side.
    task push(input logic [2:0] b, input logic [154:0] e);
        @(posedge rx_data_clk);
        {link_valid, link_buffer, link_entry} <= {1'b1, b, e};
        @(posedge rx_data_clk);
        {link_valid, link_entry} <= {1'b0, ~e};
        repeat (20) @(posedge clk);
    endtask : push
    // Pops a buffer and waits a bounded time for the word to show.
    task pop_chk(input logic [2:0] b, input logic [154:0] e);
        n = valid_count;
        u_rxf_fabric_model.pop(b);
        for (int i = 0; i < 30 && valid_count == n; i++) @(posedge clk);
        `CHK(valid_count, n + 1)
        `CHK(word, e[127:0])
        `CHK(bv, e[143:128])
        `CHK(wport, e[151:144])
        `CHK(sop, e[152])
        `CHK(eop, e[153])
        `CHK(werr, e[154])
    endtask : pop_chk
    // Prints the counts and the verdict, then ends the run.
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Watchdog sized well beyond the whole sequence.
    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
    // Four cycles of reset; the link side re-times it and stays in reset a few edges longer.
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, `RXF_ADDR_CTRL, '0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, `RXF_ADDR_EMPTY, '0);
        `CHK(rd, 32'h0000_00ff)
        apb(1'b0, 8'h40, '0);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        $display("test reset done");
        // Start word carries the top byte only; end word has an error and the low byte only.
        e0 = {3'b001, 8'h00, 16'h8000, 128'h0123_4567_89ab_cdef_0011_2233_4455_6677};
        e1 = {3'b110, 8'hff, 16'h0001, 128'hfedc_ba98_7654_3210_ffee_ddcc_bbaa_9988};
        push(3'h2, e0);
        push(3'h2, e1);
        `CHK(eflag, 8'hfb)
        pop_chk(3'h2, e0);
        pop_chk(3'h2, e1);
        `CHK(eflag, 8'hff)
        n = valid_count;
        u_rxf_fabric_model.pop(3'h2);
        repeat (20) @(posedge clk);
        `CHK(valid_count, n)
        $display("test readout done");
        // Three words sit exactly at the quarter-minus-one threshold of sixteen.
        for (int i = 0; i < 3; i++) push(3'h5, e0);
        `CHK(eflag, 8'hdf)
        apb(1'b1, `RXF_ADDR_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clk);
        `CHK(eflag, 8'hff)
        push(3'h5, e1);
        apb(1'b0, `RXF_ADDR_EMPTY, '0);
        `CHK(rd, 32'h0000_00df)
        $display("test empty type done");
        // Automatic status, then fabric status from the RAM with and without enable.
        u_rxf_fabric_model.set_pins(1'b0, 8'h05, 1'b0, 3'h0);
        repeat (10) @(posedge clk);
        `CHK(stat, 2'h1)
        u_rxf_fabric_model.write_status(1'b1, 8'h05, 2'h3);
        u_rxf_fabric_model.write_status(1'b0, 8'h05, 2'h2);
        u_rxf_fabric_model.write_status(1'b1, 8'hff, 2'h2);
        u_rxf_fabric_model.set_pins(1'b1, 8'h05, 1'b0, 3'h0);
        repeat (10) @(posedge clk);
        `CHK(stat, 2'h3)
        u_rxf_fabric_model.set_pins(1'b1, 8'hff, 1'b0, 3'h0);
        repeat (10) @(posedge clk);
        `CHK(stat, 2'h2)
        $display("test status done");
        // Every legal tap with the delay line bypassed and then inserted.
        for (int i = 0; i < 14; i++) begin
            u_rxf_fabric_model.set_pins(1'b1, 8'hff, i[0], i[3:1]);
            repeat (10) @(posedge clk);
            `CHK({dly_en, dly_tap}, i[0] ? {1'b1, i[3:1]} : 4'h0)
            apb(1'b0, `RXF_ADDR_DELAY, '0);
            `CHK(rd[3:0], i[0] ? {1'b1, i[3:1]} : 4'h0)
        end
        $display("test delay done");
        // Status clock must repeat every four link edges with equal halves.
        for (int i = 0; i < 8; i++) begin
            @(posedge rx_data_clk);
            s[i] = rsclk;
        end
        for (int i = 0; i < 6; i++) `CHK(s[i] ^ s[i + 2], 1'b1)
        $display("test status clock done");
        finish_test();
    end
endmodule : tb_top
